// *** src/adc_cfg_pkg.sv ***
package adc_cfg_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [3:0] OFS_MAIN_CTRL = 4'h0;
   localparam logic [3:0] OFS_CLK_DIV   = 4'h1;
   localparam logic [3:0] OFS_REF_CTRL  = 4'h2;
   localparam logic [3:0] OFS_CHAN_SEL  = 4'h3;
   localparam logic [3:0] OFS_STATUS    = 4'h4;
   // ------------------------------------------------------------
   // field positions and widths
   // ------------------------------------------------------------
   localparam int CS_BIT    = 4;
   localparam int NEG_REF_SELECT_BIT  = 4;
   localparam int DIV_W     = 6;
   localparam int POS_REF_SELECT_W    = 3;
   localparam int CHAN_W    = 6;
   localparam int TICK_W    = 16;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_MAIN_CTRL = 8'h00;
   localparam logic [5:0] RST_CLK_DIV   = 6'h00;
   localparam logic [2:0] RST_POS_REF   = 3'h0;
   localparam logic       RST_NEG_REF   = 1'b0;
   localparam logic [5:0] RST_CHAN      = 6'h00;
   // ------------------------------------------------------------
   // positive reference encoding
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      POS_REF_SELECT_SUPPLY  = 3'h0,
      POS_REF_SELECT_EXT_PIN = 3'h1,
      POS_REF_SELECT_FVR_1X  = 3'h2,
      POS_REF_SELECT_FVR_2X  = 3'h3,
      POS_REF_SELECT_FVR_4X  = 3'h4
   } pos_ref_select_t;
endpackage

// *** src/clk_glitchless_mux.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// clock select: enable-domain handover, no runt ticks
// ------------------------------------------------------------
module clk_glitchless_mux
   import adc_cfg_pkg::*;
(
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic sel_rc,
   input  wire logic div_tick,
   input  wire logic rc_tick,
   output logic      adc_tick,
   output logic      active_rc
);
   typedef struct packed {
      logic use_rc;
      logic pend;
      logic hold;
   } mux_st_t;
   mux_st_t q, d;
   logic    sel_tick;

   // tick of whichever source is in use now
   assign sel_tick = q.use_rc ? rc_tick : div_tick;

   // leave the old source only on its own tick, so its last period is whole,
   // then drop the first tick of the new source, whose period may be partial
   // limitation: a switch away from a stopped source never completes
   always_comb begin
      d = q;
      d.pend = (sel_rc != q.use_rc);
      if (q.hold) begin
         d.hold = !sel_tick;
      end else if (q.pend && sel_tick) begin
         d.use_rc = sel_rc;
         d.pend   = 1'b0;
         d.hold   = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign adc_tick  = sel_tick & ~q.hold;
   assign active_rc = q.use_rc;
endmodule

// *** src/adc_clock_ref_channel_config.sv ***
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
// Function
// - select bit: 0 divided system clock, 1 dedicated rc clock
// - system clock divided by 2*(n+1), n from 0 to 63
// - divider code decodes as (code+1)*2, 000000 gives divide-by-2
// - one adc clock period is the bit conversion period
// - control settings reach the core on the selected adc clock
// - divided clock tracks system clock; rc clock independent of it
// - positive reference: ext pin, supply, or fixed 1.024/2.048/4.096 v
// - negative reference bit: ext pin or ground
// - channel field picks input for sample-and-hold
module adc_clock_ref_channel_config
   import adc_cfg_pkg::*;
#(
   parameter int DIV_WIDTH = DIV_W
)(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic [3:0]        addr,
   input  wire logic [7:0]        wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [7:0]        rdata,
   input  wire logic              rc_clk_pin,
   output logic                   adc_tick,
   output logic                   bit_period_tick,
   output logic                   clk_src_rc,
   output logic      [POS_REF_SELECT_W-1:0] pos_ref_select,
   output logic                   neg_ref_select,
   output logic      [CHAN_W-1:0] channel_select_field,
   output logic      [TICK_W-1:0] tick_count
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]           main_ctrl;
      logic [DIV_WIDTH-1:0] div_sw;
      logic [POS_REF_SELECT_W-1:0]    pos_ref_select_sw;
      logic                 neg_ref_select_sw;
      logic [CHAN_W-1:0]    chan_sw;
      logic [DIV_WIDTH:0]   div_cnt;
      logic [2:0]           rc_sync;
      logic                 rc_lvl;
      logic                 rc_tick;
      logic [POS_REF_SELECT_W-1:0]    pos_ref_select_core;
      logic                 neg_ref_select_core;
      logic [CHAN_W-1:0]    chan_core;
      logic [TICK_W-1:0]    ticks;
      logic [7:0]           rdata;
   } cfg_st_t;
   cfg_st_t q, d;

   logic div_tick;
   logic mux_tick;
   logic mux_rc;

   function automatic logic [POS_REF_SELECT_W-1:0] legal_pos_ref_select(input logic [POS_REF_SELECT_W-1:0] v);
      legal_pos_ref_select = (v > POS_REF_SELECT_FVR_4X) ? POS_REF_SELECT_SUPPLY : v;
   endfunction

   // ------------------------------------------------------------
   // divider: count 0..2n+1 halves -> one tick per 2*(n+1) clks
   // ------------------------------------------------------------
   // counter runs on clk itself, so a system clock change carries straight through
   // one bit wider than the code: divide-by-128 counts 0..127
   // a code lowered mid-count waits for the wrap, at most one long period
   assign div_tick = (q.div_cnt == {q.div_sw, 1'b1});

   clk_glitchless_mux u_mux (
      .clk       (clk),
      .rstn      (rstn),
      .sel_rc    (q.main_ctrl[CS_BIT]),
      .div_tick  (div_tick),
      .rc_tick   (q.rc_tick),
      .adc_tick  (mux_tick),
      .active_rc (mux_rc)
   );

   always_comb begin
      d = q;
      d.rdata = 8'h00;
      d.div_cnt = div_tick ? '0 : q.div_cnt + 1'b1;
      // rc pin: 3 flops, a new level counts once stages 2 and 3 agree on it
      d.rc_sync = {q.rc_sync[1:0], rc_clk_pin};
      d.rc_tick = 1'b0;
      if ((q.rc_sync[1] == q.rc_sync[2]) && (q.rc_sync[2] != q.rc_lvl)) begin
         d.rc_lvl  = q.rc_sync[2];
         d.rc_tick = q.rc_sync[2];
      end
      // ------------------------------------------------------------
      // register writes and reads
      // ------------------------------------------------------------
      if (wr) begin
         case (addr)
            OFS_MAIN_CTRL: d.main_ctrl = wdata;
            OFS_CLK_DIV:   d.div_sw    = wdata[DIV_WIDTH-1:0];
            OFS_REF_CTRL: begin
               d.pos_ref_select_sw = legal_pos_ref_select(wdata[POS_REF_SELECT_W-1:0]);
               d.neg_ref_select_sw = wdata[NEG_REF_SELECT_BIT];
            end
            OFS_CHAN_SEL:  d.chan_sw   = wdata[CHAN_W-1:0];
            default:       d = d;
         endcase
      end
      if (rd) begin
         case (addr)
            OFS_MAIN_CTRL: d.rdata = q.main_ctrl;
            OFS_CLK_DIV:   d.rdata = 8'(q.div_sw);
            OFS_REF_CTRL:  d.rdata = {3'h0, q.neg_ref_select_sw, 1'b0, q.pos_ref_select_sw};
            OFS_CHAN_SEL:  d.rdata = 8'(q.chan_sw);
            OFS_STATUS:    d.rdata = {7'h00, mux_rc};
            default:       d.rdata = 8'h00;
         endcase
      end
      // ------------------------------------------------------------
      // core side
      // ------------------------------------------------------------
      // core side settings update only on the active adc clock
      if (mux_tick) begin
         d.pos_ref_select_core = q.pos_ref_select_sw;
         d.neg_ref_select_core = q.neg_ref_select_sw;
         d.chan_core = q.chan_sw;
         d.ticks     = q.ticks + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q           <= '0;
         q.main_ctrl <= RST_MAIN_CTRL;
         q.div_sw    <= DIV_WIDTH'(RST_CLK_DIV);
         q.pos_ref_select_sw   <= RST_POS_REF;
         q.neg_ref_select_sw   <= RST_NEG_REF;
         q.chan_sw   <= RST_CHAN;
         q.pos_ref_select_core <= RST_POS_REF;
         q.neg_ref_select_core <= RST_NEG_REF;
         q.chan_core <= RST_CHAN;
      end else begin
         q <= d;
      end
   end

   assign rdata                = q.rdata;
   assign adc_tick             = mux_tick;
   assign bit_period_tick      = mux_tick;
   assign clk_src_rc           = mux_rc;
   assign pos_ref_select       = q.pos_ref_select_core;
   assign neg_ref_select       = q.neg_ref_select_core;
   assign channel_select_field = q.chan_core;
   assign tick_count           = q.ticks;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [8:0] gap_cnt;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gap_cnt <= 9'h000;
      end else if (div_tick) begin
         gap_cnt <= 9'h000;
      end else begin
         gap_cnt <= gap_cnt + 9'h001;
      end
   end

   AST_DIV_PERIOD: assert property (@(posedge clk) disable iff (!rstn)
      div_tick |-> gap_cnt == 9'({q.div_sw, 1'b1}))
      else $error("divider period too long");
   AST_DIV0_EVERY2: assert property (@(posedge clk) disable iff (!rstn)
      (div_tick && q.div_sw == '0) ##2 (q.div_sw == '0) |-> div_tick)
      else $error("divide-by-2 missing");
   AST_SRC_DIV: assert property (@(posedge clk) disable iff (!rstn)
      (!mux_rc && !u_mux.q.hold) |-> (adc_tick == div_tick))
      else $error("divided source not routed");
   AST_SRC_RC: assert property (@(posedge clk) disable iff (!rstn)
      (mux_rc && !u_mux.q.hold) |-> (adc_tick == q.rc_tick))
      else $error("rc source not routed");
   AST_NO_RUNT: assert property (@(posedge clk) disable iff (!rstn)
      $changed(mux_rc) |-> $past(mux_rc ? q.rc_tick : div_tick))
      else $error("switch not on old source edge");
   AST_REF_UPD: assert property (@(posedge clk) disable iff (!rstn)
      adc_tick |=> pos_ref_select == $past(q.pos_ref_select_sw))
      else $error("reference not updated");
   AST_REF_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      !adc_tick |=> $stable(channel_select_field) && $stable(neg_ref_select))
      else $error("core setting moved off tick");
   AST_POS_REF_SELECT_LEGAL: assert property (@(posedge clk) disable iff (!rstn)
      pos_ref_select <= POS_REF_SELECT_FVR_4X)
      else $error("illegal reference code");
   AST_RD_ZERO: assert property (@(posedge clk) disable iff (!rstn)
      (rd && addr > OFS_STATUS) |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_NEG_REF_SELECT_UPD: assert property (@(posedge clk) disable iff (!rstn)
      adc_tick |=> neg_ref_select == $past(q.neg_ref_select_sw))
      else $error("negative reference not updated");
   AST_CHAN_UPD: assert property (@(posedge clk) disable iff (!rstn)
      adc_tick |=> channel_select_field == $past(q.chan_sw))
      else $error("channel not updated");
   AST_TICK_STEP: assert property (@(posedge clk) disable iff (!rstn)
      adc_tick |=> tick_count == $past(tick_count) + 1'b1)
      else $error("tick count did not step");
   AST_RD_IDLE: assert property (@(posedge clk) disable iff (!rstn)
      !rd |=> rdata == 8'h00)
      else $error("read data without read");
   AST_STATUS_RD: assert property (@(posedge clk) disable iff (!rstn)
      (rd && addr == OFS_STATUS) |=> rdata == {7'h00, $past(mux_rc)})
      else $error("status read wrong");
   AST_RC_ONE_PULSE: assert property (@(posedge clk) disable iff (!rstn)
      q.rc_tick |=> !q.rc_tick)
      else $error("rc tick longer than one cycle");

   COV_SWITCH_RC: cover property (@(posedge clk) disable iff (!rstn) $rose(mux_rc));
   COV_SWITCH_DIV: cover property (@(posedge clk) disable iff (!rstn) $fell(mux_rc));
   COV_CHAN: cover property (@(posedge clk) disable iff (!rstn) $changed(channel_select_field));
   COV_DIV128: cover property (@(posedge clk) disable iff (!rstn) div_tick && (&q.div_sw));
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
   $display("MISMATCH t=%0t %s", $time, msg); end end
module tb_top
   import adc_cfg_pkg::*;
;
   logic              clk, rstn, wr, rd, rc_clk_pin, rc_on;
   logic [3:0]        addr;
   logic [7:0]        wdata, rdata;
   logic              adc_tick, bit_period_tick, clk_src_rc, neg_ref_select;
   logic [POS_REF_SELECT_W-1:0] pos_ref_select;
   logic [CHAN_W-1:0] channel_select_field;
   logic [TICK_W-1:0] tick_count;
   int                miscompares, cmp_count, cyc, n, i, rc_div;
   logic [2:0]        e;
   logic [TICK_W-1:0] tc;
   int                codes[5] = '{0, 1, 3, 4, 63};

   adc_clock_ref_channel_config dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .rc_clk_pin(rc_clk_pin), .adc_tick(adc_tick),
      .bit_period_tick(bit_period_tick), .clk_src_rc(clk_src_rc),
      .pos_ref_select(pos_ref_select), .neg_ref_select(neg_ref_select),
      .channel_select_field(channel_select_field), .tick_count(tick_count));

   // ------------------------------------------------------------
   // clocks and run limit
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // rc source: 18-cycle period, driven on the edge; stands still when off
   always @(posedge clk) begin
      if (!rc_on) begin
         rc_div     <= 0;
         rc_clk_pin <= 1'b0;
      end else if (rc_div == 8) begin
         rc_div     <= 0;
         rc_clk_pin <= ~rc_clk_pin;
      end else begin
         rc_div <= rc_div + 1;
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         give_verdict();
      end
   end

   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] x);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK(rdata, x, "read data")
   endtask
   task automatic wait_tick();
      int k;
      for (k = 0; k < 2000; k++) begin
         @(posedge clk);
         #1;
         if (adc_tick === 1'b1) break;
      end
      `CHK(bit_period_tick, 1'b1, "bit period tick")
   endtask
   // cycles from this tick to the next one
   task automatic tick_gap(output int g);
      tc = tick_count;
      g = 0;
      do begin
         @(posedge clk);
         #1;
         g++;
      end while (adc_tick !== 1'b1 && g < 2000);
      `CHK(tick_count, tc + 16'h0001, "tick count step")
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00; rc_on = 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      for (i = 0; i < 4; i++) rd_chk(i[3:0], 8'h00);
      `CHK(pos_ref_select, 3'h0, "pos_ref_select reset")
      $display("test reset done");
      // every pos_ref_select code plus one out of range, neg bit toggled
      for (i = 0; i < 6; i++) begin
         e = (i < 5) ? i[2:0] : 3'h0;
         wr_reg(OFS_REF_CTRL, {3'h0, i[0], 1'b0, (i < 5) ? i[2:0] : 3'h7});
         rd_chk(OFS_REF_CTRL, {3'h0, i[0], 1'b0, e});
         wait_tick();
         @(posedge clk);
         #1;
         `CHK(pos_ref_select, e, "pos_ref_select route")
         `CHK(neg_ref_select, i[0], "neg_ref_select route")
      end
      wr_reg(OFS_CHAN_SEL, 8'h05);
      wr_reg(4'hA, 8'hFF); // unmapped, ignored
      rd_chk(OFS_CHAN_SEL, 8'h05);
      wait_tick();
      @(posedge clk);
      #1;
      `CHK(channel_select_field, 6'h05, "channel route")
      $display("test refs and channel done");
      // divided clock periods, boundary codes included
      foreach (codes[j]) begin
         wr_reg(OFS_CLK_DIV, codes[j][7:0]);
         wait_tick();
         tick_gap(n);
         tick_gap(n);
         `CHK(n, 2 * (codes[j] + 1), "divider period")
      end
      $display("test divider done");
      // rc source: 18-cycle ticks, delayed settings, read-only status
      rc_on = 1'b1;
      wr_reg(OFS_MAIN_CTRL, 8'h10);
      for (i = 0; i < 600 && clk_src_rc !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      `CHK(clk_src_rc, 1'b1, "rc active")
      wr_reg(OFS_STATUS, 8'h00);
      rd_chk(OFS_STATUS, 8'h01);
      wait_tick();
      tick_gap(n);
      `CHK(n, 18, "rc period")
      wr_reg(OFS_CHAN_SEL, 8'h09);
      wait_tick();
      @(posedge clk);
      #1;
      `CHK(channel_select_field, 6'h09, "rc delayed channel")
      wr_reg(OFS_MAIN_CTRL, 8'h00);
      for (i = 0; i < 600 && clk_src_rc !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      `CHK(clk_src_rc, 1'b0, "back to divider")
      rc_on = 1'b0;
      wait_tick();
      tick_gap(n);
      `CHK(n, 128, "divider after switch")
      $display("test rc source done");
      give_verdict();
   end
endmodule
